// File: core/pin_b_mode_regs.svh
// register map and field layout for the pin-b mode selector
// assumes word index addressing on the plain register port
`ifndef PIN_B_MODE_REGS_SVH
`define PIN_B_MODE_REGS_SVH
`define ADDR_IO_CTRL_CH1    4'h0
`define ADDR_IO_CTRL_CH2    4'h1
`define ADDR_GEN_B_CH1      4'h2
`define ADDR_GEN_B_CH2      4'h3
`define ADDR_COUNT_CH1      4'h4
`define ADDR_COUNT_CH2      4'h5
`define ADDR_PIN_STATUS     4'h6
`define IO_CTRL_RESET       8'h00
`define FLD_MODE_HI         7
`define FLD_MODE_LO         4
`define BIT_CAPTURE         3
`define BIT_INIT_LVL        2
`endif

// File: core/pin_b_mode_pkg.sv
// types for the pin-b mode selector
// assumes the register header is included by the top module
package pin_b_mode_pkg;
    typedef enum logic [1:0] {
        oc_off    = 2'b00,
        oc_low    = 2'b01,
        oc_high   = 2'b10,
        oc_toggle = 2'b11
    } oc_action_t;
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;
    typedef struct packed {
        logic out;
        logic oe;
    } pin_drive_t;
endpackage

// File: core/pin_b_mode.sv
// pin-b compare/capture mode selection for timer channels 1 and 2
// assumes counters and channel-0 c events come from the same clock
// Function
// R1: bit7 zero compare; bit6 initial level; 00 off
// R2: compare mode 01 drives pin low
// R3: compare mode 10 drives pin high
// R4: compare mode 11 toggles pin
// R5: capture mode 00 captures rising pin edge
// R6: capture mode 01 captures falling pin edge
// R7: bit5 set captures both edges
// R8: channel1 bits76 set captures on c0 event
// R9: channel2 ignores bit6, always pin source
// R10: initial level on write; capture copies counter
`timescale 1ns/1ps
`include "pin_b_mode_regs.svh"
module pin_b_mode (
    // clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     nrst,
    // register port
    input  wire pin_b_mode_pkg::reg_req_t req,
    output logic [15:0]                   rdata,
    // counters and channel-0 c event
    input  wire logic [15:0]              count_ch1,
    input  wire logic [15:0]              count_ch2,
    input  wire logic                     c0_event,
    // capture/compare pins
    input  wire logic [1:0]               pin_in,
    output logic [1:0]                    pin_out,
    output logic [1:0]                    pin_oe
);
    import pin_b_mode_pkg::*;

    logic [7:0]  ctrl_q [2];
    logic [7:0]  ctrl_d [2];
    logic [15:0] genb_q [2];
    logic [15:0] genb_d [2];
    logic [1:0]  out_q, out_d, oe_q, oe_d;
    logic [1:0]  sync1_q, sync2_q, prev_q;
    logic [15:0] rdata_q, rdata_d;
    logic [15:0] cnt [2];
    logic [1:0]  match, cap;

    assign cnt[0] = count_ch1;
    assign cnt[1] = count_ch2;

    // two-stage synchroniser, then a history stage for edges
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= 2'h0;
            sync2_q <= 2'h0;
            prev_q  <= 2'h0;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // per-channel mode decode, next state
    for (genvar i = 0; i < 2; i++) begin : g_ch
        logic [3:0] m;
        logic       rise, fall, ctl_wr, gen_wr;
        // the mode field sits in the upper nibble; the lower nibble is storage only
        assign m      = ctrl_q[i][`FLD_MODE_HI:`FLD_MODE_LO];
        assign rise   = sync2_q[i] & ~prev_q[i];
        assign fall   = ~sync2_q[i] & prev_q[i];
        assign ctl_wr = req.wr && req.addr == (i == 0 ? `ADDR_IO_CTRL_CH1 : `ADDR_IO_CTRL_CH2);
        assign gen_wr = req.wr && req.addr == (i == 0 ? `ADDR_GEN_B_CH1 : `ADDR_GEN_B_CH2);
        // level compare: a counter parked on the value keeps matching every cycle
        assign match[i] = (cnt[i] == genb_q[i]);
        always_comb begin
            logic [3:0] wm;
            wm         = req.wdata[`FLD_MODE_HI:`FLD_MODE_LO];
            ctrl_d[i]  = ctl_wr ? req.wdata[7:0] : ctrl_q[i];
            genb_d[i]  = gen_wr ? req.wdata : genb_q[i];
            out_d[i]   = out_q[i];
            oe_d[i]    = oe_q[i];
            cap[i]     = 1'b0;
            if (m[`BIT_CAPTURE]) begin
                if (i == 0 && m[`BIT_INIT_LVL]) begin
                    cap[i] = c0_event;                         // [R8]
                end else if (m[1]) begin
                    cap[i] = rise | fall;                      // [R7] [R9]
                end else if (m[0]) begin
                    cap[i] = fall;                             // [R6]
                end else begin
                    cap[i] = rise;                             // [R5]
                end
                if (cap[i]) begin
                    genb_d[i] = cnt[i];                        // [R10]
                end
                oe_d[i] = 1'b0;
            end else if (match[i]) begin
                case (oc_action_t'(m[1:0]))
                    oc_low:    out_d[i] = 1'b0;                // [R2]
                    oc_high:   out_d[i] = 1'b1;                // [R3]
                    oc_toggle: out_d[i] = ~out_q[i];           // [R4]
                    default:   out_d[i] = out_q[i];
                endcase
            end
            // a control write sets the initial level immediately
            if (ctl_wr) begin
                oe_d[i]  = ~wm[`BIT_CAPTURE] && wm[1:0] != 2'b00;   // [R1]
                out_d[i] = wm[`BIT_INIT_LVL];                       // [R1] [R10]
            end
        end
    end

    // read mux, data one cycle after strobe
    always_comb begin
        rdata_d = 16'h0000;
        if (req.rd) begin
            case (req.addr)
                `ADDR_IO_CTRL_CH1: rdata_d = {8'h00, ctrl_q[0]};
                `ADDR_IO_CTRL_CH2: rdata_d = {8'h00, ctrl_q[1]};
                `ADDR_GEN_B_CH1:   rdata_d = genb_q[0];
                `ADDR_GEN_B_CH2:   rdata_d = genb_q[1];
                `ADDR_PIN_STATUS:  rdata_d = {10'h000, oe_q, out_q, sync2_q};
                default:           rdata_d = 16'h0000;
            endcase
        end
    end

    // state registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q[0] <= `IO_CTRL_RESET;
            ctrl_q[1] <= `IO_CTRL_RESET;
            genb_q[0] <= 16'hFFFF;
            genb_q[1] <= 16'hFFFF;
            out_q     <= 2'h0;
            oe_q      <= 2'h0;
            rdata_q   <= 16'h0000;
        end else begin
            ctrl_q[0] <= ctrl_d[0];
            ctrl_q[1] <= ctrl_d[1];
            genb_q[0] <= genb_d[0];
            genb_q[1] <= genb_d[1];
            out_q     <= out_d;
            oe_q      <= oe_d;
            rdata_q   <= rdata_d;
        end
    end

    assign rdata   = rdata_q;
    assign pin_out = out_q;
    assign pin_oe  = oe_q;

    // checks
    a_oc_high_match: assert property (@(posedge core_clk) disable iff (!nrst)
        (ctrl_q[1][7:4] == 4'h2 && count_ch2 == genb_q[1] && !req.wr) |=> pin_out[1]) // [R3]
        else $error("high on match missing");
    a_oc_low_match: assert property (@(posedge core_clk) disable iff (!nrst)
        (ctrl_q[1][7:4] == 4'h5 && count_ch2 == genb_q[1] && !req.wr) |=> !pin_out[1]) // [R2]
        else $error("low on match missing");
    a_oc_toggle: assert property (@(posedge core_clk) disable iff (!nrst)
        (ctrl_q[0][7:4] == 4'h3 && count_ch1 == genb_q[0] && !req.wr) |=> pin_out[0] != $past(pin_out[0])) // [R4]
        else $error("toggle missing");
    a_oc_disabled: assert property (@(posedge core_clk) disable iff (!nrst)
        (ctrl_q[0][5:4] == 2'b00 || ctrl_q[0][7]) && !req.wr |=> !pin_oe[0]) // [R1]
        else $error("pin driven while disabled");
    a_cap_c0: assert property (@(posedge core_clk) disable iff (!nrst)
        (ctrl_q[0][7:6] == 2'b11 && c0_event && !req.wr) |=> genb_q[0] == $past(count_ch1)) // [R8]
        else $error("c0 capture missing");
    a_cap_rise: assert property (@(posedge core_clk) disable iff (!nrst)
        (ctrl_q[1][7:4] ==? 4'b1?00 && sync2_q[1] && !prev_q[1] && !req.wr)
        |=> genb_q[1] == $past(count_ch2)) // [R5] [R9]
        else $error("rising capture missing");
    a_cap_fall: assert property (@(posedge core_clk) disable iff (!nrst)
        (ctrl_q[1][7:4] ==? 4'b1?01 && !sync2_q[1] && prev_q[1] && !req.wr)
        |=> genb_q[1] == $past(count_ch2)) // [R6]
        else $error("falling capture missing");
    a_cap_both: assert property (@(posedge core_clk) disable iff (!nrst)
        (ctrl_q[1][7:4] ==? 4'b1?1? && sync2_q[1] != prev_q[1] && !req.wr)
        |=> genb_q[1] == $past(count_ch2)) // [R7]
        else $error("both-edge capture missing");
    a_init_level: assert property (@(posedge core_clk) disable iff (!nrst)
        (req.wr && req.addr == `ADDR_IO_CTRL_CH2 && !req.wdata[7])
        |=> pin_out[1] == $past(req.wdata[6])) // [R10]
        else $error("initial level wrong");

    // compare actions on the channels not covered above
    // high on match, channel 1, either initial level
    a_oc_high_ch1: assert property (@(posedge core_clk) disable iff (!nrst) // [R3]
        (ctrl_q[0][7:4] ==? 4'b0?10 && count_ch1 == genb_q[0] && !req.wr) |=> pin_out[0])
        else $error("channel 1 high on match missing");

    // low on match, channel 1, either initial level
    a_oc_low_ch1: assert property (@(posedge core_clk) disable iff (!nrst) // [R2]
        (ctrl_q[0][7:4] ==? 4'b0?01 && count_ch1 == genb_q[0] && !req.wr) |=> !pin_out[0])
        else $error("channel 1 low on match missing");

    // toggle on match, channel 2
    a_oc_toggle_ch2: assert property (@(posedge core_clk) disable iff (!nrst) // [R4]
        (ctrl_q[1][7:4] ==? 4'b0?11 && count_ch2 == genb_q[1] && !req.wr)
        |=> pin_out[1] != $past(pin_out[1]))
        else $error("channel 2 toggle missing");

    // disabled or capture keeps the channel 2 pin released
    a_oc_off_ch2: assert property (@(posedge core_clk) disable iff (!nrst) // [R1]
        (ctrl_q[1][5:4] == 2'b00 || ctrl_q[1][7]) && !req.wr |=> !pin_oe[1])
        else $error("channel 2 pin driven while disabled");

    // an active compare code keeps the channel 1 pin driven
    a_oc_on_ch1: assert property (@(posedge core_clk) disable iff (!nrst) // [R1]
        (!ctrl_q[0][7] && ctrl_q[0][5:4] != 2'b00 && !req.wr) |=> pin_oe[0])
        else $error("channel 1 pin not driven");

    // an active compare code keeps the channel 2 pin driven
    a_oc_on_ch2: assert property (@(posedge core_clk) disable iff (!nrst) // [R1]
        (!ctrl_q[1][7] && ctrl_q[1][5:4] != 2'b00 && !req.wr) |=> pin_oe[1])
        else $error("channel 2 pin not driven");

    // without a match the channel 1 level holds
    a_oc_hold_ch1: assert property (@(posedge core_clk) disable iff (!nrst) // [R10]
        (!ctrl_q[0][7] && count_ch1 != genb_q[0] && !req.wr) |=> $stable(pin_out[0]))
        else $error("channel 1 level moved without match");

    // without a match the channel 2 level holds
    a_oc_hold_ch2: assert property (@(posedge core_clk) disable iff (!nrst) // [R10]
        (!ctrl_q[1][7] && count_ch2 != genb_q[1] && !req.wr) |=> $stable(pin_out[1]))
        else $error("channel 2 level moved without match");

    // capture edges on the channel 1 and channel 2 pins
    // rising edge captures on channel 1
    a_cap_rise_ch1: assert property (@(posedge core_clk) disable iff (!nrst) // [R5]
        (ctrl_q[0][7:4] == 4'b1000 && sync2_q[0] && !prev_q[0] && !req.wr)
        |=> genb_q[0] == $past(count_ch1))
        else $error("channel 1 rising capture missing");

    // falling edge captures on channel 1
    a_cap_fall_ch1: assert property (@(posedge core_clk) disable iff (!nrst) // [R6]
        (ctrl_q[0][7:4] == 4'b1001 && !sync2_q[0] && prev_q[0] && !req.wr)
        |=> genb_q[0] == $past(count_ch1))
        else $error("channel 1 falling capture missing");

    // either edge captures on channel 1
    a_cap_both_ch1: assert property (@(posedge core_clk) disable iff (!nrst) // [R7]
        (ctrl_q[0][7:4] ==? 4'b101? && sync2_q[0] != prev_q[0] && !req.wr)
        |=> genb_q[0] == $past(count_ch1))
        else $error("channel 1 both-edge capture missing");

    // a quiet pin leaves channel 1 register b alone
    a_cap_quiet_ch1: assert property (@(posedge core_clk) disable iff (!nrst) // [R5]
        (ctrl_q[0][7:6] == 2'b10 && sync2_q[0] == prev_q[0] && !req.wr)
        |=> $stable(genb_q[0]))
        else $error("channel 1 capture without edge");

    // a quiet pin leaves channel 2 register b alone, whatever bit 6 says
    a_cap_quiet_ch2: assert property (@(posedge core_clk) disable iff (!nrst) // [R9]
        (ctrl_q[1][7] && sync2_q[1] == prev_q[1] && !req.wr) |=> $stable(genb_q[1]))
        else $error("channel 2 capture without edge");

    // rising-only mode ignores a falling edge on channel 2
    a_rise_only_ch2: assert property (@(posedge core_clk) disable iff (!nrst) // [R5] [R9]
        (ctrl_q[1][7:4] ==? 4'b1?00 && !sync2_q[1] && prev_q[1] && !req.wr)
        |=> $stable(genb_q[1]))
        else $error("channel 2 captured on wrong edge");

    // rising-only mode ignores a falling edge on channel 1
    a_rise_only_ch1: assert property (@(posedge core_clk) disable iff (!nrst) // [R5]
        (ctrl_q[0][7:4] == 4'b1000 && !sync2_q[0] && prev_q[0] && !req.wr)
        |=> $stable(genb_q[0]))
        else $error("channel 1 captured on falling edge");

    // falling-only mode ignores a rising edge on channel 1
    a_fall_only_ch1: assert property (@(posedge core_clk) disable iff (!nrst) // [R6]
        (ctrl_q[0][7:4] == 4'b1001 && sync2_q[0] && !prev_q[0] && !req.wr)
        |=> $stable(genb_q[0]))
        else $error("channel 1 captured on rising edge");

    // chained mode: the pin never captures, only the channel-0 event
    a_chain_quiet: assert property (@(posedge core_clk) disable iff (!nrst) // [R8]
        (ctrl_q[0][7:6] == 2'b11 && !c0_event && !req.wr) |=> $stable(genb_q[0]))
        else $error("chained capture without event");

    // register port behaviour
    // a plain register b write lands when not capturing
    a_genb_write_ch2: assert property (@(posedge core_clk) disable iff (!nrst)
        (req.wr && req.addr == `ADDR_GEN_B_CH2 && !ctrl_q[1][7])
        |=> genb_q[1] == $past(req.wdata))
        else $error("register b write lost");

    // control write sets the channel 1 initial level
    a_init_level_ch1: assert property (@(posedge core_clk) disable iff (!nrst) // [R10]
        (req.wr && req.addr == `ADDR_IO_CTRL_CH1 && !req.wdata[7])
        |=> pin_out[0] == $past(req.wdata[6]))
        else $error("channel 1 initial level wrong");

    // control write enables the channel 1 pin at once
    a_init_oe_ch1: assert property (@(posedge core_clk) disable iff (!nrst) // [R1]
        (req.wr && req.addr == `ADDR_IO_CTRL_CH1 && !req.wdata[7] && req.wdata[5:4] != 2'b00)
        |=> pin_oe[0])
        else $error("channel 1 enable late");

    // control write enables the channel 2 pin at once
    a_init_oe_ch2: assert property (@(posedge core_clk) disable iff (!nrst) // [R1]
        (req.wr && req.addr == `ADDR_IO_CTRL_CH2 && !req.wdata[7] && req.wdata[5:4] != 2'b00)
        |=> pin_oe[1])
        else $error("channel 2 enable late");

    // control readback one cycle after the strobe
    a_ctrl_read: assert property (@(posedge core_clk) disable iff (!nrst) // [R1]
        (req.rd && req.addr == `ADDR_IO_CTRL_CH1) |=> rdata == {8'h00, $past(ctrl_q[0])})
        else $error("control readback wrong");

    // register b readback one cycle after the strobe
    a_genb_read: assert property (@(posedge core_clk) disable iff (!nrst) // [R10]
        (req.rd && req.addr == `ADDR_GEN_B_CH2) |=> rdata == $past(genb_q[1]))
        else $error("register b readback wrong");

    // read data stand for one cycle only
    a_rdata_idle: assert property (@(posedge core_clk) disable iff (!nrst)
        !req.rd |=> rdata == 16'h0000)
        else $error("read data outside read cycle");

    // main scenarios reached
    c_rise_cap: cover property (@(posedge core_clk) ctrl_q[0][7:4] == 4'b1000 && sync2_q[0] && !prev_q[0]);
    c_oc_high: cover property (@(posedge core_clk) ctrl_q[1][7:4] == 4'h2 && count_ch2 == genb_q[1]);
    c_toggle: cover property (@(posedge core_clk) ctrl_q[0][7:4] == 4'h3 && count_ch1 == genb_q[0]);
    c_c0_cap: cover property (@(posedge core_clk) ctrl_q[0][7:6] == 2'b11 && c0_event);
    c_both:   cover property (@(posedge core_clk) ctrl_q[1][7] && ctrl_q[1][5] && sync2_q[1] != prev_q[1]);
endmodule

// File: testbench/pin_source.sv
// far-side model: outside sources on the two b pins
// assumes the block releases a pin by lowering its enable
`timescale 1ns/1ps
module pin_source (
    // outside levels and block drive
    input  wire logic [1:0] ext_level,
    input  wire logic [1:0] pin_out,
    input  wire logic [1:0] pin_oe,
    // resolved wire levels
    output logic [1:0]      pin_in
);
    // the block wins while it drives; a released pin shows the outside level
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
        end
    end
endmodule

// File: testbench/testbench.sv
// self-checking bench for the pin-b mode selector
// assumes the register header and package are compiled first
`timescale 1ns/1ps
`include "pin_b_mode_regs.svh"
module testbench;
    import pin_b_mode_pkg::*;
    logic        core_clk, nrst, c0_event;
    reg_req_t    req;
    logic [15:0] rdata, count_ch1, count_ch2;
    logic [1:0]  pin_in, pin_out, pin_oe, ext_level;
    int          error_cnt = 0;
    int          samples_checked = 0;
    pin_b_mode u_dut (.core_clk(core_clk), .nrst(nrst), .req(req), .rdata(rdata),
        .count_ch1(count_ch1), .count_ch2(count_ch2), .c0_event(c0_event),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    pin_source u_pins (.ext_level(ext_level), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_in(pin_in));
    // free-running 125 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // one idle edge between strobes keeps a signal from being assigned twice
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd_chk(input string what, input logic [3:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        req.rd <= 1'b0;
        @(negedge core_clk);
        chk(what, rdata, exp);
    endtask
    // counts and an outside pin level change together, then settle past the synchroniser
    task automatic drive(input int ch, input logic [15:0] cnt, input logic lvl);
        @(posedge core_clk);
        count_ch1 <= cnt;
        count_ch2 <= cnt;
        ext_level[ch] <= lvl;
        repeat (5) @(posedge core_clk);
    endtask
    task automatic t_regs();
        rd_chk("ctrl reset", `ADDR_IO_CTRL_CH1, 16'h0000);
        rd_chk("gen b reset", `ADDR_GEN_B_CH2, 16'hFFFF);
        wr(4'h4, 16'hFFFF);
        rd_chk("unmapped", 4'h4, 16'h0000);
        wr(`ADDR_IO_CTRL_CH2, 16'h00A5);
        rd_chk("ctrl readback", `ADDR_IO_CTRL_CH2, 16'h00A5);
    endtask
    // every compare code: initial level, then one single-cycle match
    task automatic t_compare(input int ch);
        logic [2:0] m;
        logic       nxt;
        for (int i = 0; i < 8; i++) begin
            m = i[2:0];
            nxt = (m[1:0] == 2'b11) ? ~m[2] : m[1];
            drive(ch, 16'h0000, 1'b0);
            wr(`ADDR_GEN_B_CH1 + ch[3:0], 16'h0010);
            wr(`ADDR_IO_CTRL_CH1 + ch[3:0], {8'h00, 1'b0, m, 4'h0});
            @(negedge core_clk);
            chk("initial", {14'h0, pin_oe[ch], pin_oe[ch] & pin_out[ch]}, {14'h0, |m[1:0], |m[1:0] & m[2]});
            // the compare is a level, so the match lasts one cycle for a single toggle
            @(posedge core_clk);
            count_ch1 <= 16'h0010;
            count_ch2 <= 16'h0010;
            @(posedge core_clk);
            count_ch1 <= 16'h0000;
            count_ch2 <= 16'h0000;
            @(negedge core_clk);
            chk("match", {14'h0, pin_oe[ch], pin_oe[ch] & pin_out[ch]}, {14'h0, |m[1:0], |m[1:0] & nxt});
        end
    endtask
    // edge codes; on channel 2 bit 6 is set and must not matter
    task automatic t_capture(input int ch);
        logic [1:0] e;
        for (int i = 0; i < 4; i++) begin
            e = i[1:0];
            wr(`ADDR_IO_CTRL_CH1 + ch[3:0], {8'h00, 1'b1, ch[0], e, 4'h0});
            drive(ch, 16'h0000, 1'b0);
            wr(`ADDR_GEN_B_CH1 + ch[3:0], 16'h0000);
            drive(ch, 16'h1234, 1'b1);
            rd_chk("rise", `ADDR_GEN_B_CH1 + ch[3:0], (e == 2'b01) ? 16'h0000 : 16'h1234);
            drive(ch, 16'h5678, 1'b0);
            rd_chk("fall", `ADDR_GEN_B_CH1 + ch[3:0], (e == 2'b00) ? 16'h1234 : 16'h5678);
        end
    endtask
    // channel 1 follows the channel-0 event, not its pin
    task automatic t_chain();
        wr(`ADDR_IO_CTRL_CH1, 16'h00F0);
        wr(`ADDR_GEN_B_CH1, 16'h0000);
        drive(0, 16'h0042, 1'b1);
        rd_chk("pin ignored", `ADDR_GEN_B_CH1, 16'h0000);
        @(posedge core_clk);
        c0_event <= 1'b1;
        count_ch1 <= 16'h0077;
        @(posedge core_clk);
        c0_event <= 1'b0;
        rd_chk("chained", `ADDR_GEN_B_CH1, 16'h0077);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        #100000;
        error_cnt++;
        results();
    end
    initial begin
        nrst = 1'b0;
        req = '0;
        count_ch1 = 16'h0000;
        count_ch2 = 16'h0000;
        c0_event = 1'b0;
        ext_level = 2'b00;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        t_regs();
        t_compare(0);
        t_compare(1);
        t_capture(0);
        t_capture(1);
        t_chain();
        results();
    end
endmodule
